// [test/sstd_far_end.sv]
// Purpose: tape reader contacts and line modem facing the sender
// Assumes: bit period fixed in cycles, start-stop frames lsb first
// Notes: reader holds its levels for the whole character period
`timescale 1ns/100ps
module sstd_far_end #(
    parameter int BIT = 20,
    parameter int GAP = 270
) (
    // clock
    input wire logic pclk,
    // reader contacts
    output logic timing_pin,
    output logic tape_present,
    output logic [7:0] level_in,
    // modem receive side
    input wire logic line_out
);
    logic [7:0] rx_char = 8'h00;
    int rx_n = 0;
    int rx_bad = 0;

    initial
    begin
        timing_pin = 1'b0;
        tape_present = 1'b0;
        level_in = 8'h00;
    end

    // one reader cycle: levels, universal contact, timing pulse
    task feed(input logic tape, input logic [7:0] chr);
        @(posedge pclk);
        tape_present <= tape;
        level_in <= chr;
        timing_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        timing_pin <= 1'b0;
        // next pulse only after the full n+2 bit frame
        repeat (GAP) @(posedge pclk);
    endtask : feed

    // sample mid-bit so edge jitter of a cycle or two is harmless
    initial
    begin
        forever
        begin
            @(negedge line_out);
            repeat (BIT / 2) @(posedge pclk);
            if (line_out !== 1'b0)
                rx_bad++;
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT) @(posedge pclk);
                rx_char = {line_out, rx_char[7:1]};
            end
            repeat (BIT) @(posedge pclk);
            if (line_out !== 1'b1)
                rx_bad++;
            rx_n++;
        end
    end
endmodule : sstd_far_end

// [test/tb.sv]
// Purpose: self-checking bench for the tape sender distributor
// Assumes: short counts via parameters, bit period of 20 cycles
// Notes: far end model decodes line frames
`timescale 1ns/100ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic timing_pin;
    logic tape_present;
    logic ext_osc_start = 1'b0;
    logic [7:0] level_in;
    logic [7:0] aux_level_in = 8'h00;
    logic line_out;
    logic sample_out;
    logic start_out;
    int n_fail = 0;
    int checked = 0;
    int n_smp = 0;
    int n_stt = 0;
    int n_low = 0;
    int n_rx = 0;

    sstd_sender #(.DLY_CYC(16'h0004), .BIT_CYC(16'h0014),
        .STOP_CYC(16'h0012), .SAMP_CYC(16'h000a)) dut (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timing_pin(timing_pin),
        .tape_present(tape_present), .ext_osc_start(ext_osc_start),
        .level_in(level_in), .aux_level_in(aux_level_in),
        .line_out(line_out), .sample_out(sample_out), .start_out(start_out));

    sstd_far_end far (.pclk(pclk),
        .timing_pin(timing_pin), .tape_present(tape_present),
        .level_in(level_in), .line_out(line_out));

    initial
    begin
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        if (sample_out === 1'b1)
            n_smp++;
        if (start_out === 1'b1)
            n_stt++;
        if (line_out !== 1'b1)
            n_low++;
    end

    task stop_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask : chk

    // no fixed latency assumed, bounded wait on pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            n_fail++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wait_rx;
        int k;
        n_rx++;
        k = 0;
        while (far.rx_n < n_rx && k < 2000)
        begin
            @(posedge pclk);
            k++;
        end
        if (k >= 2000)
        begin
            n_fail++;
            stop_test();
        end
        repeat (30) @(posedge pclk);
    endtask : wait_rx

    task t_regs;
        logic [31:0] rd;
        logic err;
        apb(1'b0, sstd_pkg::OFS_BIT, 32'h0, rd, err);
        chk("bit period", rd, 32'h14);
        apb(1'b0, sstd_pkg::OFS_SAMP, 32'h0, rd, err);
        chk("sample delay", rd, 32'h0a);
        // upper half is ignored, still slightly under one bit
        apb(1'b1, sstd_pkg::OFS_STOP, 32'hffff0011, rd, err);
        apb(1'b0, sstd_pkg::OFS_STOP, 32'h0, rd, err);
        chk("stop write", rd, 32'h11);
        apb(1'b0, 8'h20, 32'h0, rd, err);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, sstd_pkg::OFS_STAT, 32'hff, rd, err);
        chk("stat write err", 32'(err), 32'h0);
    endtask : t_regs

    // two characters back to back
    task t_frames;
        int s0;
        int t0;
        logic [31:0] rd;
        logic err;
        s0 = n_smp;
        t0 = n_stt;
        far.feed(1'b1, 8'ha5);
        wait_rx();
        chk("char a5", 32'(far.rx_char), 32'ha5);
        far.feed(1'b1, 8'h5a);
        wait_rx();
        chk("char 5a", 32'(far.rx_char), 32'h5a);
        chk("framing", 32'(far.rx_bad), 32'h0);
        chk("samples", 32'(n_smp - s0), 32'h2);
        chk("starts", 32'(n_stt - t0), 32'h2);
        apb(1'b0, sstd_pkg::OFS_LAST, 32'h0, rd, err);
        chk("last char", rd, 32'h5a);
        apb(1'b0, sstd_pkg::OFS_STAT, 32'h0, rd, err);
        chk("idle status", rd, 32'ha3);
    endtask : t_frames

    task t_aux;
        aux_level_in <= 8'h18;
        far.feed(1'b1, 8'h81);
        wait_rx();
        chk("aux or", 32'(far.rx_char), 32'h99);
        aux_level_in <= 8'h00;
    endtask : t_aux

    // start pulse still fires but the flag is refused
    task t_notape;
        int l0;
        int s0;
        int t0;
        l0 = n_low;
        s0 = n_smp;
        t0 = n_stt;
        far.feed(1'b0, 8'h3c);
        chk("no tape start", 32'(n_stt - t0), 32'h1);
        chk("no tape sample", 32'(n_smp - s0), 32'h0);
        chk("no tape mark", 32'(n_low - l0), 32'h0);
    endtask : t_notape

    task t_ext;
        logic [31:0] rd;
        logic err;
        @(posedge pclk);
        ext_osc_start <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_osc_start <= 1'b0;
        wait_rx();
        chk("ext start", 32'(far.rx_char), 32'h3c);
        // a flag still set ignores a second go, so stop it first
        far.feed(1'b0, 8'h3c);
        apb(1'b1, sstd_pkg::OFS_CTRL, 32'h1, rd, err);
        wait_rx();
        chk("ctrl start", 32'(far.rx_char), 32'h3c);
        chk("ext framing", 32'(far.rx_bad), 32'h0);
    endtask : t_ext

    initial
    begin
        repeat (3) @(posedge pclk);
        chk("reset line", 32'(line_out), 32'h1);
        chk("reset sample", 32'(sample_out), 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_frames();
        t_aux();
        t_notape();
        t_ext();
        stop_test();
    end
endmodule : tb

// [verilog/sstd_oneshot.sv]
// Purpose: counted one-shot, active for len cycles after trig
// Assumes: trig is a one-cycle pulse
// Notes: a new trig restarts the interval
`timescale 1ns/100ps
module sstd_oneshot #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    sstd_os_if.os os
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic active;
        logic done;
    } sstd_os_t;
    sstd_os_t st_ff;
    sstd_os_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (os.trig)
        begin
            nxt_st.cnt = (os.len == '0) ? W'(1) : os.len;
            nxt_st.active = 1'b1;
        end
        else if (st_ff.active)
        begin
            if (st_ff.cnt <= W'(1))
            begin
                nxt_st.active = 1'b0;
                nxt_st.done = 1'b1;
            end
            else
                nxt_st.cnt = st_ff.cnt - W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign os.active = st_ff.active;
    assign os.done = st_ff.done;
endmodule : sstd_oneshot

// [verilog/sstd_os_if.sv]
// Purpose: trigger and status of one counted one-shot
// Assumes: one clock
// Notes: len of zero acts as one
`timescale 1ns/100ps
interface sstd_os_if #(parameter int W = 16);
    logic trig;
    logic [W-1:0] len;
    logic active;
    logic done;
    modport ctl (output trig, output len, input active, input done);
    modport os (input trig, input len, output active, output done);
endinterface : sstd_os_if

// [verilog/sstd_pkg.sv]
// Purpose: shared constants for the tape sender distributor
// Assumes: pclk at 125 MHz
// Notes: register offsets are byte addresses on apb
package sstd_pkg;
    localparam int CLK_NS = 8;
    localparam int DLY_NS = 50000;
    localparam int CNT_W = 16;
    // longest delay, so rounded down
    localparam logic [15:0] DLY_RST = 16'(DLY_NS / CLK_NS);
    localparam logic [15:0] BIT_RST = 16'h30d4;
    localparam logic [15:0] STOP_RST = 16'h2ee0;
    localparam logic [15:0] SAMP_RST = 16'h186a;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BIT = 8'h04;
    localparam logic [7:0] OFS_STOP = 8'h08;
    localparam logic [7:0] OFS_SAMP = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_LAST = 8'h14;
    localparam int CTRL_GO_BIT = 0;
endpackage : sstd_pkg

// [verilog/sstd_sender.sv]
// Purpose: start-stop serial sender fed by a paper tape reader
// Assumes: levels <= 8; bit period >= 2 cycles
// Notes: apb slave, one wait-free access per transfer
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module sstd_sender #(
    parameter int LEVELS = 8,
    parameter logic [15:0] DLY_CYC = sstd_pkg::DLY_RST,
    parameter logic [15:0] BIT_CYC = sstd_pkg::BIT_RST,
    parameter logic [15:0] STOP_CYC = sstd_pkg::STOP_RST,
    parameter logic [15:0] SAMP_CYC = sstd_pkg::SAMP_RST
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reader and auxiliary pins
    input wire logic timing_pin,
    input wire logic tape_present,
    input wire logic ext_osc_start,
    input wire logic [LEVELS-1:0] level_in,
    input wire logic [7:0] aux_level_in,
    // outputs
    output logic line_out,
    output logic sample_out,
    output logic start_out
);
    localparam int N = LEVELS;
    localparam int CW = sstd_pkg::CNT_W;
    localparam int SW = N + 11;
    localparam logic [3:0] PMAX = 4'(N + 2);

    typedef struct packed {
        logic tp_q;
        logic dly;
        logic dly_q;
        logic osc;
        logic osc_q;
        logic [CW-1:0] ocnt;
        logic [3:0] pcnt;
        logic [N:0] shreg;
        logic start;
        logic sample;
        logic sw_go;
        logic [CW-1:0] bitc;
        logic [CW-1:0] stopc;
        logic [CW-1:0] sampc;
        logic [N-1:0] last;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sstd_st_t;

    sstd_st_t st_ff;
    sstd_st_t nxt_st;

    logic [SW-1:0] sy;
    logic tp_s;
    logic univ_s;
    logic ext_s;
    logic [N-1:0] lvl_s;
    logic [7:0] aux_s;
    logic [N-1:0] load_v;
    logic dly_rise;
    logic go;
    logic pulse;
    logic clr;
    logic adv;

    sstd_os_if #(.W(CW)) rise_if ();
    sstd_os_if #(.W(CW)) fall_if ();
    sstd_os_if #(.W(CW)) stop_if ();
    sstd_os_if #(.W(CW)) smp_if ();

    sstd_sync #(.W(SW)) u_sync (
        .pclk (pclk),
        .presetn (presetn),
        .d ({timing_pin, tape_present, ext_osc_start, level_in,
             aux_level_in}),
        .q (sy)
    );

    assign {tp_s, univ_s, ext_s, lvl_s, aux_s} = sy;

    sstd_oneshot #(.W(CW)) u_rise (
        .pclk (pclk),
        .presetn (presetn),
        .os (rise_if)
    );

    sstd_oneshot #(.W(CW)) u_fall (
        .pclk (pclk),
        .presetn (presetn),
        .os (fall_if)
    );

    sstd_oneshot #(.W(CW)) u_stop (
        .pclk (pclk),
        .presetn (presetn),
        .os (stop_if)
    );

    sstd_oneshot #(.W(CW)) u_smp (
        .pclk (pclk),
        .presetn (presetn),
        .os (smp_if)
    );

    // both edges delayed by the same count keeps the shape
    assign rise_if.trig = tp_s & ~st_ff.tp_q;
    assign fall_if.trig = ~tp_s & st_ff.tp_q;
    assign rise_if.len = DLY_CYC;
    assign fall_if.len = DLY_CYC;
    assign dly_rise = st_ff.dly & ~st_ff.dly_q;
    assign stop_if.trig = dly_rise;
    assign stop_if.len = st_ff.stopc;
    assign smp_if.trig = st_ff.osc & ~st_ff.osc_q;
    assign smp_if.len = st_ff.sampc;
    assign go = (stop_if.done & univ_s) | ext_s | st_ff.sw_go;
    // pulse one cycle after start, so sample delay is already up
    assign pulse = st_ff.osc && st_ff.ocnt == CW'(1)
        && st_ff.pcnt < PMAX;
    assign clr = pulse & smp_if.active;
    assign adv = pulse & ~smp_if.active;
    assign load_v = lvl_s | aux_s[N-1:0];

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tp_q = tp_s;
        nxt_st.dly_q = st_ff.dly;
        nxt_st.osc_q = st_ff.osc;
        // rising copy wins should both edges land together
        if (fall_if.done)
            nxt_st.dly = 1'b0;
        if (rise_if.done)
            nxt_st.dly = 1'b1;
        if (dly_rise)
            nxt_st.osc = 1'b0;
        // set wins over the clear
        if (go)
            nxt_st.osc = 1'b1;
        if (st_ff.osc)
        begin
            if (st_ff.ocnt >= st_ff.bitc - CW'(1))
                nxt_st.ocnt = '0;
            else
                nxt_st.ocnt = st_ff.ocnt + CW'(1);
        end
        else
            nxt_st.ocnt = '0;
        if (smp_if.trig)
            nxt_st.pcnt = '0;
        else if (pulse)
            nxt_st.pcnt = st_ff.pcnt + 4'h1;
        if (clr)
            nxt_st.shreg = '0;
        else if (adv)
            nxt_st.shreg = {1'b1, st_ff.shreg[N:1]};
        if (smp_if.done)
        begin
            nxt_st.shreg[N:1] = nxt_st.shreg[N:1] | load_v;
            nxt_st.last = load_v;
        end
        nxt_st.start = stop_if.done;
        nxt_st.sample = smp_if.done;
        nxt_st.sw_go = 1'b0;
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        if (psel && !penable)
        begin
            nxt_st.pready = 1'b1;
            nxt_st.prdata = '0;
            unique case (paddr)
                sstd_pkg::OFS_CTRL:
                    nxt_st.prdata = '0;
                sstd_pkg::OFS_BIT:
                    nxt_st.prdata[CW-1:0] = st_ff.bitc;
                sstd_pkg::OFS_STOP:
                    nxt_st.prdata[CW-1:0] = st_ff.stopc;
                sstd_pkg::OFS_SAMP:
                    nxt_st.prdata[CW-1:0] = st_ff.sampc;
                sstd_pkg::OFS_STAT:
                    nxt_st.prdata[7:0] = {st_ff.pcnt, stop_if.active,
                        smp_if.active, st_ff.osc, st_ff.shreg[0]};
                sstd_pkg::OFS_LAST:
                    nxt_st.prdata[N-1:0] = st_ff.last;
                default:
                    nxt_st.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && st_ff.pready && pwrite && !st_ff.pslverr)
        begin
            unique case (paddr)
                sstd_pkg::OFS_CTRL:
                    nxt_st.sw_go = pwdata[sstd_pkg::CTRL_GO_BIT];
                sstd_pkg::OFS_BIT:
                    nxt_st.bitc = pwdata[CW-1:0];
                sstd_pkg::OFS_STOP:
                    nxt_st.stopc = pwdata[CW-1:0];
                sstd_pkg::OFS_SAMP:
                    nxt_st.sampc = pwdata[CW-1:0];
                default:
                    nxt_st.sw_go = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '0;
            st_ff.shreg <= '1;
            st_ff.bitc <= BIT_CYC;
            st_ff.stopc <= STOP_CYC;
            st_ff.sampc <= SAMP_CYC;
        end
        else
            st_ff <= nxt_st;
    end

    assign line_out = st_ff.shreg[0];
    assign sample_out = st_ff.sample;
    assign start_out = st_ff.start;
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;

    // checks
    logic [N-1:0] hi_v;
    assign hi_v = st_ff.shreg[N:1];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_DLY_EDGE: assert property (
        rise_if.done |=> st_ff.dly)
        else $error("delayed timing level did not rise");
    AST_OSC_CLEAR: assert property (
        (dly_rise && !go) |=> !st_ff.osc ##1 stop_if.active)
        else $error("delayed pulse did not stop oscillator");
    AST_START_GATE: assert property (
        (stop_if.done && !univ_s && !ext_s && !st_ff.sw_go
         && !st_ff.osc) |=> !st_ff.osc)
        else $error("start pulse passed without tape");
    AST_OSC_SET: assert property (
        (stop_if.done && univ_s) |=> st_ff.osc)
        else $error("start pulse did not set oscillator flag");
    AST_SMP_TRIG: assert property (
        $rose(st_ff.osc) |=> smp_if.active)
        else $error("sample delay not started with oscillator");
    AST_PULSE_MAX: assert property (
        st_ff.pcnt <= PMAX)
        else $error("too many oscillator pulses in a character");
    AST_CLEAR_SPACE: assert property (
        clr |=> !line_out && st_ff.shreg == '0)
        else $error("clear did not make the start space");
    AST_SHIFT: assert property (
        (adv && !smp_if.done) |=>
        st_ff.shreg == {1'b1, $past(hi_v)})
        else $error("advance did not shift toward output");
    AST_SAMPLE_OUT: assert property (
        smp_if.done |=> sample_out ##1 !sample_out)
        else $error("sample lead pulse wrong");
    AST_START_OUT: assert property (
        stop_if.done |=> start_out)
        else $error("start lead pulse missing");
    AST_HOLD_MARK: assert property (
        (!st_ff.osc && line_out) |=> line_out)
        else $error("line left mark without advances");
    AST_NO_ADV_CLEAR: assert property (
        clr |-> st_ff.pcnt == 4'h0)
        else $error("clear was not the first pulse");
    // a code load outside the bit between the clear and the first advance garbles a frame
    AST_SAMP_LATE: assert property (
        (smp_if.done && st_ff.osc) |-> st_ff.pcnt == 4'h1)
        else $error("code loaded before or after the start space");
    AST_LOAD_MARKS: assert property (
        smp_if.done |=> st_ff.last == $past(load_v)
        && (st_ff.shreg[N:1] & $past(load_v)) == $past(load_v))
        else $error("marked level not set in register");
    AST_STOP_AFTER: assert property (
        (adv && st_ff.pcnt == PMAX - 4'h1) |=> line_out)
        else $error("stop mark missing after last code bit");
    AST_DLY_FALL: assert property (
        fall_if.done |=> !st_ff.dly)
        else $error("delayed timing level did not fall");
    AST_START_ONE: assert property (
        start_out |=> !start_out)
        else $error("start lead pulse too long");
    AST_RESET_MARK: assert property (
        $rose(presetn) |-> line_out && !sample_out && !start_out)
        else $error("line not at mark after reset");

    // bus checks
    AST_APB_ONE: assert property (
        pready |=> !pready)
        else $error("pready stood longer than one cycle");
    AST_APB_ERR: assert property (
        pslverr |-> pready)
        else $error("error response without pready");
    AST_WRITE_LAND: assert property (
        (psel && penable && pready && pwrite
         && paddr == sstd_pkg::OFS_STOP)
        |=> st_ff.stopc == $past(pwdata[CW-1:0]))
        else $error("stop timer write did not land");

    COV_SAMPLE: cover property (smp_if.done ##1 sample_out);
    COV_EXT: cover property ($rose(st_ff.osc) && ext_s);
    COV_STOP: cover property (adv && st_ff.pcnt == PMAX - 4'h1);
    COV_BLOCKED: cover property (stop_if.done && !univ_s);
    COV_CHAR: cover property (clr ##[1:1000] adv);
endmodule : sstd_sender

// [verilog/sstd_sync.sv]
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins are asynchronous to pclk
// Notes: stage one feeds stage two only
`timescale 1ns/100ps
module sstd_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins and result
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sstd_sync_t;
    sstd_sync_t st_ff;
    sstd_sync_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_ff.s2[i] == st_ff.s3[i])
                nxt_st.q[i] = st_ff.s3[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign q = st_ff.q;
endmodule : sstd_sync
